// *** verif/icw_checker.sv ***
// Purpose: wire-level checks on the two-wire link
// Assumes: both ends joined by icw_if
// Notes: HALF must match the master instance
`timescale 1ns/10ps
module icw_checker #(
  parameter int HALF = icw_pkg::SCL_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire scl_line,
  input wire sda_line
);
  localparam int LIM = HALF + HALF / 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // lines released when reset ends
  property p_rst_idle;
    $rose(rst_n) |-> !scl_oe_m && !sda_oe_m && !sda_oe_s;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("line driven after reset");
  // ack slot: master must be off the data wire
  property p_no_fight;
    sda_oe_s && scl_line |-> !sda_oe_m;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data");
  // slave moves data only while clock low
  property p_slv_low;
    $changed(sda_oe_s) |-> !scl_line;
  endproperty
  a_slv_low: assert property (p_slv_low)
    else $error("slave moved data with clock high");
  // start keeps data low until clock falls
  property p_start_hold;
    $fell(sda_line) && scl_line |-> !sda_line until !scl_line;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start not held");
  property p_start_bound;
    $fell(sda_line) && scl_line |-> ##[1:LIM] !scl_line;
  endproperty
  a_start_bound: assert property (p_start_bound)
    else $error("no clock after start");
  // stop leaves data high
  property p_stop_idle;
    $rose(sda_line) && scl_line |=> sda_line [*2];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("data dropped after stop");
  // bit clock high and low phases
  property p_high_min;
    $rose(scl_line) |-> scl_line [*8];
  endproperty
  a_high_min: assert property (p_high_min)
    else $error("clock high too short");
  property p_low_max;
    $fell(scl_line) |-> ##[1:LIM] scl_line;
  endproperty
  a_low_max: assert property (p_low_max)
    else $error("clock low too long");
endmodule : icw_checker

// *** verif/testbench.sv ***
// Purpose: write packets from master end into slave end
// Assumes: short bit time, HALF of 20 clocks
// Notes: expected port storage kept in the bench
`timescale 1ns/10ps
module testbench;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [6:0] slave_addr = 7'h00;
  logic [1:0] port = 2'h0;
  logic [11:0] addr = 12'h000;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [2:0] strap = 3'h0;
  logic busy, done, nacked, commit;
  logic [1:0] commit_port;
  logic [11:0] commit_addr;
  logic [31:0] commit_data;
  logic [3:0] commit_be;
  logic [31:0] port_reg [icw_pkg::NUM_PORTS];
  logic [31:0] exp_reg [3] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int commits = 0;
  icw_if ifc();
  icw_master #(.HALF(20)) i_icw_master (.clk(clk), .rst_n(rst_n), .bus(ifc), .req(req),
    .slave_addr(slave_addr), .port(port), .addr(addr), .be(be), .wdata(wdata),
    .busy(busy), .done(done), .nacked(nacked));
  icw_slave i_icw_slave (.clk(clk), .rst_n(rst_n), .bus(ifc), .addr_strap(strap),
    .commit(commit), .commit_port(commit_port), .commit_addr(commit_addr),
    .commit_data(commit_data), .commit_be(commit_be), .port_reg(port_reg));
  icw_checker #(.HALF(20)) i_icw_checker (.clk(clk), .rst_n(rst_n), .scl_oe_m(ifc.scl_oe_m),
    .sda_oe_m(ifc.sda_oe_m), .sda_oe_s(ifc.sda_oe_s), .scl_line(ifc.scl_line),
    .sda_line(ifc.sda_line));
  always #5 clk = ~clk;
  // cycle ceiling and commit pulse count
  always @(posedge clk) begin
    cycles++;
    if (commit === 1'b1) commits++;
    if (cycles == 80000) begin
      miscompares++;
      results();
    end
  end
  task results;
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // enabled bytes take new data, others keep old
  function automatic logic [31:0] merge(input logic [31:0] old, d, input logic [3:0] e);
    for (int i = 0; i < 4; i++) merge[8*i+:8] = e[i] ? d[8*i+:8] : old[8*i+:8];
  endfunction : merge
  task send(input logic [6:0] sa, input logic [1:0] p, input logic [11:0] a,
    input logic [3:0] e, input logic [31:0] d);
    int n;
    int c0;
    logic ok;
    ok = (sa == {icw_pkg::ADDR_FIXED, strap});
    c0 = commits;
    slave_addr <= sa;
    port <= p;
    addr <= a;
    be <= e;
    wdata <= d;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 20000, 1'b1)
    `CHK(nacked, !ok)
    `CHK(busy, 1'b0)
    `CHK(commits - c0, (ok && p != 2'h3) ? 1 : 0)
    if (ok && p != 2'h3) begin
      exp_reg[p] = merge(exp_reg[p], d, e);
      `CHK(commit_port, p)
      `CHK(commit_addr, {a[11:2], 2'b00})
      `CHK(commit_be, e)
      `CHK(commit_data, d)
    end
    for (int k = 0; k < 3; k++) `CHK(port_reg[k], exp_reg[k])
  endtask : send
  initial begin
    void'($urandom(32'h67ff4bd1));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    send(7'h38, 2'h0, 12'h0b4, 4'hf, 32'h1234_5678);
    send(7'h38, 2'h3, 12'h0b4, 4'hf, 32'hdead_beef);
    send(7'h38, 2'h0, 12'h0b7, 4'h0, 32'h0bad_0bad);
    send(7'h39, 2'h1, 12'hfff, 4'hf, 32'hffff_ffff);
    for (int t = 0; t < 9; t++) begin
      strap <= 3'($urandom);
      repeat (4) @(posedge clk);
      send(($urandom % 4 == 0) ? 7'($urandom) : {4'h7, strap}, 2'($urandom),
        12'($urandom), 4'($urandom), $urandom);
    end
    results();
  end
endmodule : testbench

// *** verilog/icw_if.sv ***
// Purpose: two-wire bus joining master and slave ends
// Assumes: open drain wires with pull-ups resolved here
// Notes: a driven enable pulls the wire low
`timescale 1ns/10ps
interface icw_if;
  logic scl_out_m;
  logic scl_oe_m;
  logic sda_out_m;
  logic sda_oe_m;
  logic sda_out_s;
  logic sda_oe_s;
  wire scl_line;
  wire sda_line;
  // wired-and of the drivers: master alone on scl, both ends on sda
  assign scl_line = ~(scl_oe_m & ~scl_out_m);
  assign sda_line = ~((sda_oe_m & ~sda_out_m) | (sda_oe_s & ~sda_out_s));
  modport master (output scl_out_m, output scl_oe_m, output sda_out_m, output sda_oe_m,
    input scl_line, input sda_line);
  modport slave (output sda_out_s, output sda_oe_s, input scl_line, input sda_line);
endinterface : icw_if

// *** verilog/icw_master.sv ***
// Purpose: i2c master that sends one register write packet per request
// Assumes: scl made here by dividing clk
// Notes: nack on any byte aborts with a stop
`timescale 1ns/10ps
module icw_master #(
  parameter int HALF = icw_pkg::SCL_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  icw_if.master bus,
  input wire logic req,
  input wire logic [6:0] slave_addr,
  input wire logic [1:0] port,
  input wire logic [11:0] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic busy,
  output logic done,
  output logic nacked
);
  typedef enum logic [1:0] {
    ICM_IDLE = 2'b00, ICM_START = 2'b01, ICM_BITS = 2'b10, ICM_STOP = 2'b11
  } icm_state_t;
  icm_state_t state;
  logic [71:0] frame;
  logic [3:0] bitn;
  logic [3:0] byten;
  logic [15:0] tick;
  logic phase;
  logic scl_o;
  logic sda_o;
  logic [1:0] sda_s;
  wire half_end = tick == 16'(HALF - 1);
  // data changes mid-way through a low half, never near a clock edge
  wire mid_low = tick == 16'(HALF / 2);
  wire [71:0] image = {slave_addr, 1'b0, 5'h00, icw_pkg::OP_WRITE, 7'h00, port[1],
    port[0], 1'b0, be, addr[11:10], addr[9:2], wdata};

  // input synchroniser for sda
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sda_s <= 2'h3;
    else sda_s <= {sda_s[0], bus.sda_line};
  end

  // bit timing and sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ICM_IDLE;
      frame <= 72'h0;
      bitn <= 4'h0;
      byten <= 4'h0;
      tick <= 16'h0000;
      phase <= 1'b0;
      scl_o <= 1'b1;
      sda_o <= 1'b1;
      done <= 1'b0;
      nacked <= 1'b0;
    end else begin
      done <= 1'b0;
      tick <= half_end ? 16'h0000 : tick + 16'h0001;
      case (state)
        ICM_IDLE: begin
          tick <= 16'h0000;
          if (req) begin
            frame <= image;
            nacked <= 1'b0;
            state <= ICM_START;
          end
        end
        ICM_START: begin
          if (half_end) begin
            sda_o <= 1'b0;
            phase <= ~phase;
            if (phase) begin
              scl_o <= 1'b0;
              bitn <= 4'h0;
              byten <= 4'h0;
              phase <= 1'b0;
              state <= ICM_BITS;
            end
          end
        end
        ICM_BITS: begin
          // next bit, or release for the ack, while clock is low
          if (mid_low && !phase) sda_o <= (bitn == 4'h8) ? 1'b1 : frame[71];
          if (half_end) begin
            phase <= ~phase;
            if (!phase) scl_o <= 1'b1;
            else begin
              scl_o <= 1'b0;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                byten <= byten + 4'h1;
                // stop after last byte or nack
                if (sda_s[1] || byten == 4'h8) begin
                  nacked <= sda_s[1];
                  state <= ICM_STOP;
                end
              end else begin
                bitn <= bitn + 4'h1;
                frame <= {frame[70:0], 1'b0};
              end
            end
          end
        end
        default: begin
          // pull data low in the low half, raise clock, then release data
          if (mid_low && !phase) sda_o <= 1'b0;
          if (half_end) begin
            phase <= ~phase;
            if (!phase) scl_o <= 1'b1;
            else begin
              sda_o <= 1'b1;
              done <= 1'b1;
              state <= ICM_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign busy = state != ICM_IDLE;
  assign bus.scl_out_m = scl_o;
  assign bus.scl_oe_m = ~scl_o;
  assign bus.sda_out_m = sda_o;
  assign bus.sda_oe_m = ~sda_o;
endmodule : icw_master

// *** verilog/icw_pkg.sv ***
// Purpose: shared constants for the i2c configuration write link
// Assumes: 100 MHz system clock on both ends
// Notes: command byte fields, address straps and bit timing counts
package icw_pkg;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam int OP_LSB = 0;
  localparam int PSEL_HI_BIT = 0;
  localparam int PSEL_LO_BIT = 7;
  localparam int BE_LSB = 2;
  localparam int ADDR_HI_LSB = 0;
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  localparam int CMD_BYTES = 4;
  localparam int DATA_BYTES = 4;
  localparam int NUM_PORTS = 3;
  localparam int CLK_MHZ = 100;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = SCL_HALF_NS * CLK_MHZ / 1000;
  localparam logic [1:0] RST_STATE = 2'h0;
endpackage : icw_pkg

// *** verilog/icw_slave.sv ***
// Purpose: i2c slave that decodes register write packets for three ports
// Assumes: scl and sda are asynchronous, synchronised before use
// Notes: register storage is kept per port, one dword per port
//   the commit strobe and its fields let a host mirror every write
//   invalid commands are acknowledged in full but never committed
//   only the master drives the clock; this end never stretches it
//
// Overview of operation
// - opcode in byte0 bits 2:0, 011b writes
// - port select from byte1 bit0, byte2 bit7
// - write goes to the selected port
// - byte2 bits 5:2 are byte enables
// - disabled bytes keep their old value
// - address from byte2 1:0 and byte3
// - master sends start, address, write bit
// - data arrives msb byte first
// - extra data bytes get a nack
// - invalid commands leave registers unchanged
// - address is 0111 plus three straps
// - master ends with stop or repeated start
`timescale 1ns/10ps
module icw_slave #(
  parameter int NPORT = icw_pkg::NUM_PORTS
) (
  input wire logic clk,
  input wire logic rst_n,
  icw_if.slave bus,
  input wire logic [2:0] addr_strap,
  output logic commit,
  output logic [1:0] commit_port,
  output logic [11:0] commit_addr,
  output logic [31:0] commit_data,
  output logic [3:0] commit_be,
  output logic [31:0] port_reg [NPORT]
);
  typedef enum logic [1:0] {
    ICW_IDLE = 2'b00,
    ICW_RECV = 2'b01,
    ICW_ACK = 2'b10,
    ICW_SKIP = 2'b11
  } icw_state_t;
  icw_state_t state;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [3:0] bytecnt;
  logic [7:0] cmd [4];
  logic [31:0] data;
  logic ack_drive;
  logic [2:0] strap;
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  wire [7:0] byte_in = {shreg[6:0], sda_s[1]};
  // own address match, on the completed byte
  wire [6:0] own_addr = {icw_pkg::ADDR_FIXED, strap};
  wire addr_hit = shreg[7:1] == own_addr && !shreg[0];
  wire [1:0] psel = {cmd[1][icw_pkg::PSEL_HI_BIT], cmd[2][icw_pkg::PSEL_LO_BIT]};
  wire op_ok = cmd[0][2:0] == icw_pkg::OP_WRITE;
  wire cmd_ok = op_ok && (32'(psel) < NPORT);
  // which part of the packet the byte is
  wire addr_slot = bytecnt == 4'h0;
  wire cmd_slot = bytecnt >= 4'h1 && bytecnt <= 4'h4;
  wire data_slot = bytecnt >= 4'h5 && bytecnt <= 4'h8;
  // accept only four data bytes after four commands
  wire byte_ok = addr_slot ? addr_hit : (bytecnt <= 4'h8);

  // synchronisers for both wires
  // delayed copies start high, the idle level, so reset makes no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], bus.scl_line};
      sda_s <= {sda_s[0], bus.sda_line};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // strap capture after reset release
  // straps are read only between packets, so one packet sees one address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) strap <= 3'h0;
    else if (state == ICW_IDLE) strap <= addr_strap;
  end

  // byte receiver and ack sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ICW_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
      ack_drive <= 1'b0;
      data <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) cmd[i] <= 8'h00;
    end else if (start_c) begin
      // a start, repeated or not, restarts the decode
      state <= ICW_RECV;
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
      ack_drive <= 1'b0;
    end else if (stop_c) begin
      // stop ends the packet and frees the wire
      state <= ICW_IDLE;
      ack_drive <= 1'b0;
    end else begin
      case (state)
        ICW_RECV: begin
          if (scl_rise) begin
            // shift in on every rising clock
            shreg <= byte_in;
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              if (data_slot) data <= {data[23:0], byte_in};
              // command bytes fill slots 0 to 3
              if (cmd_slot) cmd[bytecnt[1:0] - 2'h1] <= byte_in;
            end
          end else if (scl_fall && bitcnt == 4'h8) begin
            ack_drive <= byte_ok;
            state <= byte_ok ? ICW_ACK : ICW_SKIP;
          end
        end
        ICW_ACK: begin
          // release the ack when its clock falls
          if (scl_fall) begin
            ack_drive <= 1'b0;
            bitcnt <= 4'h0;
            bytecnt <= bytecnt + 4'h1;
            state <= ICW_RECV;
          end
        end
        ICW_SKIP: begin
          // off the wire until the next start
          if (scl_fall) state <= ICW_IDLE;
        end
        default: begin
          // idle waits for a start condition
          ack_drive <= 1'b0;
        end
      endcase
    end
  end

  assign bus.sda_out_s = 1'b0;
  assign bus.sda_oe_s = ack_drive;

  // commit after fourth data byte ack
  wire last_ack = state == ICW_ACK && scl_fall && bytecnt == 4'h8;
  wire fire = last_ack && cmd_ok;
  wire [11:0] waddr = {cmd[2][1:0], cmd[3], 2'b00};
  wire [3:0] be = cmd[2][icw_pkg::BE_LSB +: 4];
  // selected port only; enabled bytes only
  logic [3:0] byte_wr [NPORT];
  for (genvar gp = 0; gp < NPORT; gp++) begin : g_port
    // a port strobes only while its number is selected
    assign byte_wr[gp] = (fire && 32'(psel) == gp) ? be : 4'h0;
  end

  // commit strobe and the fields that describe it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      commit <= 1'b0;
      commit_port <= 2'h0;
      commit_addr <= 12'h000;
      commit_data <= 32'h0000_0000;
      commit_be <= 4'h0;
    end else begin
      commit <= fire;
      if (fire) begin
        commit_port <= psel;
        commit_addr <= waddr;
        commit_data <= data;
        commit_be <= be;
      end
    end
  end

  // per port register storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NPORT; p++) port_reg[p] <= 32'h0000_0000;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        for (int b = 0; b < 4; b++) begin
          // byte lanes follow their strobes
          if (byte_wr[p][b]) port_reg[p][b*8 +: 8] <= data[b*8 +: 8];
        end
      end
    end
  end
endmodule : icw_slave
